/* cmpmon_defs.svh */
// Purpose: Offsets, fields, reset values and codes of the compare monitor
// Assumes: Included by bare name; definitions only
// Notes:   All values are `define macros; types live in the package
`ifndef CMPMON_DEFS_SVH
`define CMPMON_DEFS_SVH

// ==========================================================
// Register byte offsets
`define CMPMON_OFS_CTRL      8'h00
`define CMPMON_OFS_THRESH    8'h04
`define CMPMON_OFS_STATUS    8'h08
`define CMPMON_OFS_FAULT     8'h0c
`define CMPMON_OFS_MONCTRL   8'h10
`define CMPMON_OFS_MONSTAT   8'h14
`define CMPMON_OFS_IRQSTAT   8'h18
`define CMPMON_OFS_IRQMASK   8'h1c

// ==========================================================
// Comparator and monitor control field positions
`define CMPMON_CTRL_EN       0
`define CMPMON_CTRL_CH_LO    4
`define CMPMON_CTRL_COND_LO  8
`define CMPMON_CTRL_TGT_LO   12
`define CMPMON_CTRL_ACT      16
`define CMPMON_CTRL_SRC_LO   17
`define CMPMON_MON_EN        0
`define CMPMON_MON_CLR_LO    8

// ==========================================================
// Condition codes and fault codes
`define CMPMON_COND_EQ       2'h0
`define CMPMON_COND_GE       2'h1
`define CMPMON_COND_LE       2'h2
`define CMPMON_FAULT_NONE    32'h00000000
`define CMPMON_FAULT_COND    32'h00000001
`define CMPMON_FAULT_AXIS    32'h00000002
`define CMPMON_FAULT_EXEC    32'h00000003

// ==========================================================
// Interrupt bits and reset values
`define CMPMON_IRQ_ERROR     0
`define CMPMON_IRQ_RESULT    1
`define CMPMON_RST_WORD      32'h00000000
`define CMPMON_RST_RESULTS   8'h00
`endif

/* cmpmon_pkg.sv */
// Purpose: Types shared by the compare monitor
// Assumes: Used with cmpmon_defs.svh
// Notes:   Types only
package cmpmon_pkg;
	// ==========================================================
	// Comparator sequence states, one-hot
	typedef enum logic [3:0] {
		CMPMON_IDLE  = 4'h1,
		CMPMON_ARM   = 4'h2,
		CMPMON_RUN   = 4'h4,
		CMPMON_FAULT = 4'h8
	} cmpmon_state_type;
	// Monitor sequence states, one-hot
	typedef enum logic [2:0] {
		CMPMON_MIDLE = 3'h1,
		CMPMON_MARM  = 3'h2,
		CMPMON_MRUN  = 3'h4
	} cmpmon_mstate_type;
endpackage : cmpmon_pkg

/* cmpmon_compare_output_monitor.sv */
// Purpose: Fast comparator block plus comparator result clear unit on AHB-Lite
// Assumes: One scan cycle is one clk_sys cycle (40 MHz); inputs synchronous
// Notes:   One comparator engine; channel number is latched and reported
`timescale 1ns/1ps
`include "cmpmon_defs.svh"

module cmpmon_compare_output_monitor
	import cmpmon_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        srst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Compare sources: four axis positions, four counter values
	input  wire logic [31:0] axisPosition0,
	input  wire logic [31:0] axisPosition1,
	input  wire logic [31:0] axisPosition2,
	input  wire logic [31:0] axisPosition3,
	input  wire logic [31:0] counterValue0,
	input  wire logic [31:0] counterValue1,
	input  wire logic [31:0] counterValue2,
	input  wire logic [31:0] counterValue3,
	// Axis and execution health
	input  wire logic [3:0]  axisErrorStop,
	input  wire logic        execFault,
	// Target outputs
	output logic      [3:0]  outputPoint,
	output logic      [3:0]  counterResetReq,
	output logic      [3:0]  axisHalt,
	// Monitor status outputs
	output logic             point8ResultState,
	output logic             point9ResultState,
	output logic             point10ResultState,
	output logic             point11ResultState,
	output logic             counter0ResetResultState,
	output logic             counter1ResetResultState,
	output logic             counter2ResetResultState,
	output logic             counter3ResetResultState,
	// Interrupt
	output logic             irq
);

	// ==========================================================
	// Software registers
	logic [31:0]      ctrlReg;          // Comparator control
	logic [31:0]      thresholdReg;     // Compare threshold
	logic [31:0]      monCtrlReg;       // Monitor enable and clears
	logic [1:0]       irqStatus;        // Sticky events
	logic [1:0]       irqMask;          // Event mask
	// Comparator state
	cmpmon_state_type state;            // Comparator sequence
	cmpmon_mstate_type mstate;          // Monitor sequence
	logic             enPrev;           // Enable one scan ago
	logic [3:0]       chanLatch;        // Latched channel
	logic [1:0]       condLatch;        // Latched condition
	logic [2:0]       tgtLatch;         // Latched target
	logic             actLatch;         // Latched action
	logic [2:0]       srcLatch;         // Latched source
	logic [31:0]      threshLatch;      // Latched threshold
	logic [31:0]      faultCode;        // Recorded fault code
	logic             errorFlag;        // Error output
	logic [7:0]       results;          // Latched target results
	// Bus data-phase capture
	logic             wrPending;        // Write in data phase
	logic [7:0]       wrAddr;           // Its offset

	// ==========================================================
	// Field decode
	wire logic        cmpEnable  = ctrlReg[`CMPMON_CTRL_EN];
	wire logic        monEnable  = monCtrlReg[`CMPMON_MON_EN];
	wire logic [7:0]  clearReq   = monCtrlReg[`CMPMON_MON_CLR_LO +: 8];
	wire logic        enRise     = cmpEnable & ~enPrev;
	wire logic        enFall     = ~cmpEnable & enPrev;
	wire logic [1:0]  condNew    = ctrlReg[`CMPMON_CTRL_COND_LO +: 2];

	// Source selection for the compare; the health check indexes axisErrorStop directly
	function automatic logic [31:0] pick_source(input logic [2:0] sel,
		input logic [31:0] a0, input logic [31:0] a1,
		input logic [31:0] a2, input logic [31:0] a3,
		input logic [31:0] c0, input logic [31:0] c1,
		input logic [31:0] c2, input logic [31:0] c3);
		logic [31:0] v;
		v = a0;
		case (sel)
			3'h1: v = a1;
			3'h2: v = a2;
			3'h3: v = a3;
			3'h4: v = c0;
			3'h5: v = c1;
			3'h6: v = c2;
			3'h7: v = c3;
			default: v = a0;
		endcase
		return v;
	endfunction : pick_source

	wire logic [31:0] srcValue = pick_source(srcLatch, axisPosition0, axisPosition1,
		axisPosition2, axisPosition3, counterValue0, counterValue1,
		counterValue2, counterValue3);

	// Compare is signed: thresholds may be negative
	// condition codes
	wire logic cmpTrue =
		(condLatch == `CMPMON_COND_EQ) ? (srcValue == threshLatch) :
		(condLatch == `CMPMON_COND_GE) ? ($signed(srcValue) >= $signed(threshLatch)) :
		(condLatch == `CMPMON_COND_LE) ? ($signed(srcValue) <= $signed(threshLatch)) :
		1'b0;

	// Health of the selected source: axis sources 0..3 only
	wire logic axisBad  = ~srcLatch[2] & axisErrorStop[srcLatch[1:0]];
	wire logic running  = (state == CMPMON_ARM) | (state == CMPMON_RUN);
	wire logic runFault = running & cmpEnable & (execFault | axisBad);
	wire logic condBad  = enRise & (condNew > `CMPMON_COND_LE);

	// ==========================================================
	// Handshake outputs
	// busy follows enable at once
	wire logic cmpBusy  = cmpEnable & (state != CMPMON_FAULT) & ~condBad & ~runFault;
	// valid drops with enable or error
	wire logic cmpValid = running & cmpEnable & ~runFault;
	wire logic monValid = (mstate == CMPMON_MRUN) & monEnable;
	wire logic monBusy  = monEnable;

	// Action on hit: one bit per target
	// target codes 0-3 points, 4-7 counters
	wire logic [7:0] tgtOneHot = 8'h01 << tgtLatch;
	wire logic       hit       = cmpValid & cmpTrue;

	// ==========================================================
	// Comparator sequence
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state <= CMPMON_IDLE;
			enPrev <= 1'b0;
			errorFlag <= 1'b0;
			faultCode <= `CMPMON_FAULT_NONE;
		end
		else
		begin
			enPrev <= cmpEnable;
			case (state)
				CMPMON_IDLE:
				begin
					// Latch setup on the rising edge
					if (condBad)
					begin
						state <= CMPMON_FAULT;
						errorFlag <= 1'b1;
						faultCode <= `CMPMON_FAULT_COND;
					end
					else if (enRise)
						state <= CMPMON_ARM;
				end
				CMPMON_ARM, CMPMON_RUN:
				begin
					if (!cmpEnable)
						state <= CMPMON_IDLE;
					else if (runFault)
					begin
						state <= CMPMON_FAULT;
						errorFlag <= 1'b1;
						faultCode <= execFault ? `CMPMON_FAULT_EXEC : `CMPMON_FAULT_AXIS;
					end
					else
						state <= CMPMON_RUN;
				end
				CMPMON_FAULT:
				begin
					if (enFall)
					begin
						state <= CMPMON_IDLE;
						errorFlag <= 1'b0;
						faultCode <= `CMPMON_FAULT_NONE;
					end
				end
				default: state <= CMPMON_IDLE;
			endcase
		end
	end

	// Setup latched only on the enable edge
	// channel latched at enable rise
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			chanLatch <= 4'h0;
			condLatch <= 2'h0;
			tgtLatch <= 3'h0;
			actLatch <= 1'b0;
			srcLatch <= 3'h0;
			threshLatch <= `CMPMON_RST_WORD;
		end
		else if (enRise)
		begin
			chanLatch <= ctrlReg[`CMPMON_CTRL_CH_LO +: 4];
			condLatch <= condNew;
			tgtLatch <= ctrlReg[`CMPMON_CTRL_TGT_LO +: 3];
			actLatch <= ctrlReg[`CMPMON_CTRL_ACT];
			srcLatch <= ctrlReg[`CMPMON_CTRL_SRC_LO +: 3];
			threshLatch <= thresholdReg;
		end
	end

	// ==========================================================
	// Result latches: set by a set-action hit, cleared by a reset-action hit or the monitor
	// Hit wins over a clear in the same scan, so no event is lost
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_result
			// ge with set turns point on
			wire logic setIt = hit & tgtOneHot[gi] & actLatch;
			wire logic rstIt = hit & tgtOneHot[gi] & ~actLatch;
			wire logic clrIt = monEnable & clearReq[gi];
			always_ff @(posedge clk_sys)
			begin
				if (srst)
					results[gi] <= 1'b0;
				else if (setIt)
					results[gi] <= 1'b1;
				else if (rstIt | clrIt)
					results[gi] <= 1'b0;
			end
		end
	endgenerate

	// Monitor sequence
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			mstate <= CMPMON_MIDLE;
		else
		begin
			case (mstate)
				CMPMON_MIDLE: mstate <= monEnable ? CMPMON_MARM : CMPMON_MIDLE;
				CMPMON_MARM:  mstate <= monEnable ? CMPMON_MRUN : CMPMON_MIDLE;
				CMPMON_MRUN:  mstate <= monEnable ? CMPMON_MRUN : CMPMON_MIDLE;
				default:      mstate <= CMPMON_MIDLE;
			endcase
		end
	end

	// Registered target and status outputs
	// status false until valid
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			outputPoint <= 4'h0;
			counterResetReq <= 4'h0;
			axisHalt <= 4'h0;
			{counter3ResetResultState, counter2ResetResultState,
				counter1ResetResultState, counter0ResetResultState,
				point11ResultState, point10ResultState,
				point9ResultState, point8ResultState} <= `CMPMON_RST_RESULTS;
		end
		else
		begin
			outputPoint <= results[3:0];
			// Counter reset request is high the scan after each set-action hit on a counter target
			counterResetReq <= {4{hit & actLatch}} & tgtOneHot[7:4];
			// halt the selected source axis until the fault is cleared
			// A refused condition code never moved an axis, so it halts none
			axisHalt <= (errorFlag & (faultCode != `CMPMON_FAULT_COND) & ~srcLatch[2]) ?
				(4'h1 << srcLatch[1:0]) : 4'h0;
			{counter3ResetResultState, counter2ResetResultState,
				counter1ResetResultState, counter0ResetResultState,
				point11ResultState, point10ResultState,
				point9ResultState, point8ResultState} <= results & {8{monValid}};
		end
	end

	// ==========================================================
	// Interrupt events: error rise and any result rising
	logic [7:0] resultsPrev;            // For rise detection
	logic       errorPrev;              // For rise detection
	wire logic [1:0] irqEvent = {|(results & ~resultsPrev), errorFlag & ~errorPrev};
	wire logic       irqWrite = wrPending & (wrAddr == `CMPMON_OFS_IRQSTAT);
	wire logic [1:0] irqClear = irqWrite ? hwdata[1:0] : 2'h0;

	// Sticky status, set beats write-one-clear
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			irqStatus <= 2'h0;
			resultsPrev <= 8'h00;
			errorPrev <= 1'b0;
		end
		else
		begin
			resultsPrev <= results;
			errorPrev <= errorFlag;
			irqStatus <= (irqStatus & ~irqClear) | irqEvent;
		end
	end
	assign irq = |(irqStatus & irqMask);

	// ==========================================================
	// AHB-Lite slave: zero wait states, always OKAY
	wire logic       addrPhase = hsel & htrans[1] & hready;
	wire logic [7:0] rdAddr    = haddr[7:0];
	wire logic [31:0] rdMux =
		(rdAddr == `CMPMON_OFS_CTRL)    ? ctrlReg :
		(rdAddr == `CMPMON_OFS_THRESH)  ? thresholdReg :
		(rdAddr == `CMPMON_OFS_STATUS)  ? {24'h0, chanLatch, 1'b0, errorFlag, cmpBusy, cmpValid} :
		(rdAddr == `CMPMON_OFS_FAULT)   ? faultCode :
		(rdAddr == `CMPMON_OFS_MONCTRL) ? monCtrlReg :
		(rdAddr == `CMPMON_OFS_MONSTAT) ? {16'h0, results, 6'h0, monBusy, monValid} :
		(rdAddr == `CMPMON_OFS_IRQSTAT) ? {30'h0, irqStatus} :
		(rdAddr == `CMPMON_OFS_IRQMASK) ? {30'h0, irqMask} :
		32'h00000000;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Address phase capture and read data register
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wrPending <= 1'b0;
			wrAddr <= 8'h00;
			hrdata <= `CMPMON_RST_WORD;
		end
		else
		begin
			wrPending <= addrPhase & hwrite;
			wrAddr <= rdAddr;
			if (addrPhase & ~hwrite)
				hrdata <= rdMux;
		end
	end

	// Register writes in the data phase
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ctrlReg <= `CMPMON_RST_WORD;
			thresholdReg <= `CMPMON_RST_WORD;
			monCtrlReg <= `CMPMON_RST_WORD;
			irqMask <= 2'h0;
		end
		else if (wrPending)
		begin
			if (wrAddr == `CMPMON_OFS_CTRL)
				ctrlReg <= hwdata;
			else if (wrAddr == `CMPMON_OFS_THRESH)
				thresholdReg <= hwdata;
			else if (wrAddr == `CMPMON_OFS_MONCTRL)
				monCtrlReg <= hwdata;
			else if (wrAddr == `CMPMON_OFS_IRQMASK)
				irqMask <= hwdata[1:0];
		end
	end

endmodule : cmpmon_compare_output_monitor

/* cmpmon_compare_output_monitor_properties.sv */
// Purpose: Port-level checks of the compare monitor
// Assumes: Single clock domain, srst synchronous active high
// Notes:   Bound to the top module; the bind follows endmodule
`timescale 1ns/1ps
// ==========================================================
// Checker
module cmpmon_compare_output_monitor_properties (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        srst,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Faults and targets
	input wire logic [3:0]  axisErrorStop,
	input wire logic        execFault,
	input wire logic [3:0]  outputPoint,
	input wire logic [3:0]  counterResetReq,
	input wire logic [3:0]  axisHalt,
	input wire logic        point8ResultState,
	input wire logic        point9ResultState,
	input wire logic        point10ResultState,
	input wire logic        point11ResultState,
	input wire logic        irq
);
	// Read request taken on this edge
	wire logic rdReq   = hsel && htrans[1] && hready && !hwrite;
	// Any fault source, so halts can be traced to a cause
	wire logic faultIn = (|axisErrorStop) || execFault;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_reset_quiet: assert property ($past(srst) |-> !irq && outputPoint == 4'h0 && axisHalt == 4'h0)
		else $error("outputs not clear after reset");
	a_status_points: assert property (({point11ResultState, point10ResultState, point9ResultState, point8ResultState} & ~outputPoint) == 4'h0)
		else $error("status without point result");
	a_halt_cause: assert property ($rose(|axisHalt) |-> $past(faultIn) || $past(faultIn, 2))
		else $error("halt without fault");
	a_halt_single: assert property ($onehot0(axisHalt))
		else $error("more than one axis halted");
	a_unmapped_read: assert property (rdReq && haddr[7:0] >= 8'h20 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!$past(rdReq) |-> $stable(hrdata))
		else $error("read data moved without read");
endmodule : cmpmon_compare_output_monitor_properties

bind cmpmon_compare_output_monitor cmpmon_compare_output_monitor_properties u_cmpmon_compare_output_monitor_properties (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hrdata, .hreadyout, .hresp, .axisErrorStop, .execFault, .outputPoint, .counterResetReq,
	.axisHalt, .point8ResultState, .point9ResultState, .point10ResultState,
	.point11ResultState, .irq);

/* cmpmon_compare_output_monitor_tb_top.sv */
// Purpose: Self-checking bench of the compare monitor
// Assumes: Zero-wait AHB-Lite slave, one scan is one clock
// Notes:   pins packs halt, pulse, point and status bits for compares
`timescale 1ns/1ps
`include "cmpmon_defs.svh"
module cmpmon_compare_output_monitor_tb_top import cmpmon_pkg::*;;
	// ==========================================================
	// Stimulus and observed signals
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] axisPosition0 = 32'h0;
	logic [31:0] counterValue0 = 32'h0;
	logic [31:0] counterValue1 = 32'h0;
	logic [3:0]  axisErrorStop = 4'h0;
	logic        execFault = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic [3:0]  outputPoint;
	logic [3:0]  counterResetReq;
	logic [3:0]  axisHalt;
	logic [7:0]  resState;
	wire  logic  hready = hreadyout;
	wire  logic [31:0] pins = {12'h0, axisHalt, counterResetReq, outputPoint, resState};
	int          errorCnt = 0;
	int          compares = 0;

	always #12.5 clk_sys = ~clk_sys;

	cmpmon_compare_output_monitor u_cmpmon_compare_output_monitor (.clk_sys, .srst, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.axisPosition0, .axisPosition1(32'h0), .axisPosition2(32'h0), .axisPosition3(32'h0),
		.counterValue0, .counterValue1, .counterValue2(32'h0), .counterValue3(32'h0),
		.axisErrorStop, .execFault, .outputPoint, .counterResetReq, .axisHalt,
		.point8ResultState(resState[0]), .point9ResultState(resState[1]),
		.point10ResultState(resState[2]), .point11ResultState(resState[3]),
		.counter0ResetResultState(resState[4]), .counter1ResetResultState(resState[5]),
		.counter2ResetResultState(resState[6]), .counter3ResetResultState(resState[7]), .irq);

	// ==========================================================
	// Shared tasks
	task automatic close_out;
		$display("errors %0d compares %0d", errorCnt, compares);
		if (errorCnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex)
		begin
			errorCnt++;
			$display("FAIL %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	// Bounded wait for hready at a rising edge
	task automatic waitRdy;
		int n;
		n = 0;
		do @(posedge clk_sys); while (hready !== 1'b1 && ++n < 16);
		if (n >= 16)
		begin
			errorCnt++;
			close_out();
		end
	endtask : waitRdy

	// One single word transfer, address then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex,
		input logic [31:0] m = 32'hffffffff);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, ex, q & m);
	endtask : rdc

	// Let the edge's updates land before sampling
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : settle

	// ==========================================================
	// Scenarios
	task automatic ge_point;
		counterValue1 <= 32'h3e7;
		wr(`CMPMON_OFS_THRESH, 32'h3e8);
		wr(`CMPMON_OFS_CTRL, 32'h000b01f1);
		rdc("status", `CMPMON_OFS_STATUS, 32'h0f3);
		rdc("chan", `CMPMON_OFS_STATUS, 32'hf0, 32'hf0);
		@(posedge clk_sys) counterValue1 <= 32'h3e8;
		settle(4);
		chk("pins ge", 32'h100, pins);
		wr(`CMPMON_OFS_MONCTRL, 32'h1);
		settle(3);
		chk("pins mon", 32'h101, pins);
		rdc("monstat", `CMPMON_OFS_MONSTAT, 32'h103);
		@(posedge clk_sys) counterValue1 <= 32'h3e7;
		wr(`CMPMON_OFS_MONCTRL, 32'h101);
		settle(3);
		chk("pins clr", 32'h0, pins);
		rdc("irqstat", `CMPMON_OFS_IRQSTAT, 32'h2, 32'h2);
		wr(`CMPMON_OFS_MONCTRL, 32'h1);
		wr(`CMPMON_OFS_CTRL, 32'h0);
		rdc("status off", `CMPMON_OFS_STATUS, 32'h0, 32'h7);
	endtask : ge_point

	task automatic counter_pulse;
		logic seen;
		seen = 1'b0;
		wr(`CMPMON_OFS_THRESH, 32'h0);
		wr(`CMPMON_OFS_CTRL, 32'h00014001);
		repeat (8)
		begin
			settle(1);
			seen = seen | counterResetReq[0];
		end
		chk("pulse", 32'h1, {31'h0, seen});
		chk("cnt state", 32'h10, pins & 32'hfff);
		wr(`CMPMON_OFS_CTRL, 32'h0);
		wr(`CMPMON_OFS_MONCTRL, 32'h1001);
		settle(2);
		chk("cnt clr", 32'h0, pins & 32'hff);
		wr(`CMPMON_OFS_MONCTRL, 32'h1);
	endtask : counter_pulse

	task automatic le_action;
		counterValue0 <= 32'h5;
		wr(`CMPMON_OFS_THRESH, 32'ha);
		wr(`CMPMON_OFS_CTRL, 32'h00091201);
		settle(5);
		chk("le set", 32'h202, pins);
		wr(`CMPMON_OFS_CTRL, 32'h0);
		wr(`CMPMON_OFS_CTRL, 32'h00081201);
		settle(5);
		chk("le reset", 32'h0, pins);
		wr(`CMPMON_OFS_CTRL, 32'h0);
	endtask : le_action

	task automatic refusal;
		wr(`CMPMON_OFS_IRQSTAT, 32'h3);
		wr(`CMPMON_OFS_IRQMASK, 32'h1);
		wr(`CMPMON_OFS_CTRL, 32'h301);
		rdc("status err", `CMPMON_OFS_STATUS, 32'h4, 32'h7);
		rdc("fault", `CMPMON_OFS_FAULT, `CMPMON_FAULT_COND);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(`CMPMON_OFS_IRQSTAT, 32'h1);
		settle(1);
		chk("irq off", 32'h0, {31'h0, irq});
		wr(`CMPMON_OFS_CTRL, 32'h0);
		rdc("status clr", `CMPMON_OFS_STATUS, 32'h0, 32'h7);
		rdc("fault clr", `CMPMON_OFS_FAULT, `CMPMON_FAULT_NONE);
	endtask : refusal

	task automatic axis_fault;
		wr(`CMPMON_OFS_THRESH, 32'h7fffffff);
		wr(`CMPMON_OFS_CTRL, 32'h00052101);
		rdc("busy", `CMPMON_OFS_STATUS, 32'h3, 32'h7);
		@(posedge clk_sys) axisErrorStop <= 4'h4;
		settle(3);
		rdc("status stop", `CMPMON_OFS_STATUS, 32'h4, 32'h7);
		rdc("fault axis", `CMPMON_OFS_FAULT, `CMPMON_FAULT_AXIS);
		chk("halt", 32'h40000, pins);
		chk("irq err", 32'h1, {31'h0, irq});
		@(posedge clk_sys) axisErrorStop <= 4'h0;
		wr(`CMPMON_OFS_CTRL, 32'h0);
		wr(`CMPMON_OFS_CTRL, 32'h00052101);
		@(posedge clk_sys) execFault <= 1'b1;
		settle(3);
		rdc("fault exec", `CMPMON_OFS_FAULT, `CMPMON_FAULT_EXEC);
		@(posedge clk_sys) execFault <= 1'b0;
		wr(`CMPMON_OFS_CTRL, 32'h0);
		settle(2);
		chk("halt off", 32'h0, pins);
	endtask : axis_fault

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		rdc("status rst", `CMPMON_OFS_STATUS, 32'h0);
		rdc("fault rst", `CMPMON_OFS_FAULT, 32'h0);
		rdc("unmapped", 8'h20, 32'h0);
		ge_point();
		counter_pulse();
		le_action();
		refusal();
		axis_fault();
		close_out();
	end
endmodule : cmpmon_compare_output_monitor_tb_top
